// ===== include/gio_pkg.sv
////////////////////////////////////////////////////////////////////////////////
// Shared constants and types for the pin I/O logic
////////////////////////////////////////////////////////////////////////////////
`default_nettype none
package gio_pkg;

  // Register port geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;

  // Control register layout: bits [14:0] hold gio_cfg_type, the rest read zero
  localparam int unsigned CTRL_USED_W = 15;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // Status register bit positions
  localparam int unsigned STAT_PAD_BIT = 0;
  localparam int unsigned STAT_RISE_BIT = 1;
  localparam int unsigned STAT_FALL_BIT = 2;
  localparam int unsigned STAT_OE_BIT = 3;
  localparam int unsigned STAT_CFG_BIT = 4;
  localparam int unsigned STAT_PU_BIT = 5;
  localparam int unsigned STAT_PD_BIT = 6;

  // Reset values of the pad pull flops: the pin starts inside configuration
  localparam logic PULL_UP_RST = 1'b1;
  localparam logic PULL_DOWN_RST = 1'b0;

  // Pin operating modes
  typedef enum logic [2:0] {
    GIO_MODE_UNUSED = 3'b000,
    GIO_MODE_INPUT  = 3'b001,
    GIO_MODE_OUTPUT = 3'b010,
    GIO_MODE_BIDIR  = 3'b011,
    GIO_MODE_CLKOUT = 3'b100
  } gio_mode_type;

  // Control fields, MSB first; mode occupies bits [2:0]
  typedef struct packed {
    logic diff_pin;    // 14: pin is differential-capable, used single-ended
    logic pull_down;   // 13: unused pin pulls down instead of up, or has no pull at all when diff_pin is set
    logic alt_sel;     // 12: in input mode the pad feeds the alternate path only
    logic dual_edge_out; // 11: dual-edge drive
    logic dual_edge_in; // 10: dual-edge capture
    logic out_inv;     // 9
    logic oe_fall;     // 8
    logic oe_reg;      // 7
    logic out_fall;    // 6
    logic out_reg;     // 5
    logic in_fall;     // 4
    logic in_reg;      // 3
    gio_mode_type mode; // 2:0
  } gio_cfg_type;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } gio_bus_req_type;

  // Core-side drive bundle
  typedef struct packed {
    logic data_rise;   // Data driven, and rising-edge data in dual-edge mode
    logic data_fall;   // Falling-edge data in dual-edge mode
    logic oe;
  } gio_drive_type;

endpackage
`default_nettype wire

// ===== hw/gio_edge_reg.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// One I/O register with a flop on each clock edge and a selectable output
////////////////////////////////////////////////////////////////////////////////
module gio_edge_reg #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic d_rise_i,
  input wire logic d_fall_i,
  input wire logic fall_sel_i,
  output logic q_o,
  output logic q_rise_o,
  output logic q_fall_o
);

  logic rise_r;
  logic rise_nxt;
  logic fall_r;
  logic fall_nxt;

  // Both edges always run; selection afterwards avoids gating the clock
  always_comb begin
    rise_nxt = d_rise_i;
    fall_nxt = d_fall_i;
  end

  // Rising-edge flop
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rise_r <= RST_VAL;
    end else begin
      rise_r <= rise_nxt;
    end
  end

  // Falling-edge flop
  always_ff @(negedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fall_r <= RST_VAL;
    end else begin
      fall_r <= fall_nxt;
    end
  end

  assign q_o = fall_sel_i ? fall_r : rise_r;
  assign q_rise_o = rise_r;
  assign q_fall_o = fall_r;

endmodule // gio_edge_reg
`default_nettype wire

// ===== hw/gio_io_logic.sv
`timescale 1ns/1ps
`default_nettype none
module gio_io_logic (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic cfg_active_i,
  input wire gio_pkg::gio_bus_req_type bus_req_i,
  output logic [31:0] rd_data_o,
  input wire gio_pkg::gio_drive_type core_drive_i,
  output logic rise_sample_out_o,
  output logic fall_sample_out_o,
  output logic alt_path_o,
  input wire logic pad_i,
  output logic pad_o,
  output logic pad_oe_o,
  output logic pull_up_o,
  output logic pull_down_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Clocks and configuration
  ////////////////////////////////////////////////////////////////////////////
  logic capture_side_clock;
  logic drive_side_clock;
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [31:0] rd_data_r;
  logic [31:0] rd_data_nxt;
  logic [31:0] status;
  gio_pkg::gio_cfg_type cfg;
  logic in_mode;
  logic drive_mode;
  logic bidir_mode;

  // Both dedicated core clocks are taps of the core tree, never user nets
  assign capture_side_clock = clk_i;
  assign drive_side_clock = clk_i;

  assign cfg = gio_pkg::gio_cfg_type'(ctrl_r[gio_pkg::CTRL_USED_W-1:0]);
  assign bidir_mode = (cfg.mode == gio_pkg::GIO_MODE_BIDIR);
  // Receive path only in input and bidir, drive path only in output and bidir
  assign in_mode = (cfg.mode == gio_pkg::GIO_MODE_INPUT) || bidir_mode;
  assign drive_mode = (cfg.mode == gio_pkg::GIO_MODE_OUTPUT) || bidir_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  ////////////////////////////////////////////////////////////////////////////
  // Write decode and read mux; unmapped reads return zero
  always_comb begin
    ctrl_nxt = ctrl_r;
    rd_data_nxt = 32'h0000_0000;
    if (bus_req_i.wr && bus_req_i.addr == gio_pkg::CTRL_OFS) begin
      ctrl_nxt = {17'h0_0000, bus_req_i.wdata[gio_pkg::CTRL_USED_W-1:0]};
    end
    if (bus_req_i.rd) begin
      if (bus_req_i.addr == gio_pkg::CTRL_OFS) begin
        rd_data_nxt = ctrl_r;
      end else if (bus_req_i.addr == gio_pkg::STATUS_OFS) begin
        rd_data_nxt = status;
      end else begin
        rd_data_nxt = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_r <= gio_pkg::CTRL_RST;
      rd_data_r <= 32'h0000_0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  assign rd_data_o = rd_data_r;

  ////////////////////////////////////////////////////////////////////////////
  // Receive path
  ////////////////////////////////////////////////////////////////////////////
  logic in_q;
  logic in_q_rise;
  logic in_q_fall;
  logic pad_meta_r;
  logic pad_sync_r;
  logic pad_meta_nxt;
  logic pad_sync_nxt;

  // Input register captures the pad; the core sees the pad through it only while in_reg is set
  gio_edge_reg #(
    .RST_VAL(1'b0)
  ) u_in_reg (
    .clk_i(capture_side_clock),
    .arst_n_i(arst_n_i),
    .d_rise_i(pad_i),
    .d_fall_i(pad_i),
    .fall_sel_i(cfg.in_fall),
    .q_o(in_q),
    .q_rise_o(in_q_rise),
    .q_fall_o(in_q_fall)
  );

  // Core-facing capture outputs; the input registering choice ignores out_reg
  always_comb begin
    rise_sample_out_o = 1'b0;
    fall_sample_out_o = 1'b0;
    if (in_mode && !cfg.alt_sel) begin
      if (!cfg.in_reg) begin
        rise_sample_out_o = pad_i;
      end else if (cfg.dual_edge_in) begin
        rise_sample_out_o = in_q_rise;
        fall_sample_out_o = in_q_fall;
      end else begin
        rise_sample_out_o = in_q;
      end
    end
  end

  // Alternate path: straight wire to the neighbouring block, no register
  assign alt_path_o = (cfg.mode == gio_pkg::GIO_MODE_INPUT) && cfg.alt_sel && pad_i;

  // Software view of the pad level goes through two flops first
  always_comb begin
    pad_meta_nxt = pad_i;
    pad_sync_nxt = pad_meta_r;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pad_meta_r <= 1'b0;
      pad_sync_r <= 1'b0;
    end else begin
      pad_meta_r <= pad_meta_nxt;
      pad_sync_r <= pad_sync_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive path
  ////////////////////////////////////////////////////////////////////////////
  logic out_q;
  logic out_q_rise;
  logic out_q_fall;
  logic oe_q;
  logic out_reg_val;
  logic out_val;
  logic oe_val;

  // Output register; in dual-edge mode the falling flop takes the second bit
  gio_edge_reg #(
    .RST_VAL(1'b0)
  ) u_out_reg (
    .clk_i(drive_side_clock),
    .arst_n_i(arst_n_i),
    .d_rise_i(core_drive_i.data_rise),
    .d_fall_i(cfg.dual_edge_out ? core_drive_i.data_fall : core_drive_i.data_rise),
    .fall_sel_i(cfg.out_fall),
    .q_o(out_q),
    .q_rise_o(out_q_rise),
    .q_fall_o(out_q_fall)
  );

  // Output enable register shares the drive-side clock
  gio_edge_reg #(
    .RST_VAL(1'b0)
  ) u_oe_reg (
    .clk_i(drive_side_clock),
    .arst_n_i(arst_n_i),
    .d_rise_i(core_drive_i.oe),
    .d_fall_i(core_drive_i.oe),
    .fall_sel_i(cfg.oe_fall),
    .q_o(oe_q),
    .q_rise_o(),
    .q_fall_o()
  );

  // Dual-edge mux follows the clock level so each half shows its own flop
  always_comb begin
    out_reg_val = cfg.dual_edge_out ? (drive_side_clock ? out_q_rise : out_q_fall) : out_q;
    out_val = cfg.out_reg ? (out_reg_val ^ cfg.out_inv) : core_drive_i.data_rise;
    oe_val = cfg.oe_reg ? oe_q : core_drive_i.oe;
  end

  // Pad driver; clock mode takes the tree directly, not a core data bit
  always_comb begin
    pad_o = 1'b0;
    pad_oe_o = 1'b0;
    if (!cfg_active_i) begin
      if (cfg.mode == gio_pkg::GIO_MODE_CLKOUT) begin
        pad_o = drive_side_clock;
        pad_oe_o = 1'b1;
      end else if (cfg.mode == gio_pkg::GIO_MODE_OUTPUT) begin
        pad_o = out_val;
        pad_oe_o = 1'b1;
      end else if (bidir_mode) begin
        pad_o = out_val;
        pad_oe_o = oe_val;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad pulls
  ////////////////////////////////////////////////////////////////////////////
  logic pull_up_r;
  logic pull_up_nxt;
  logic pull_down_r;
  logic pull_down_nxt;

  // For a plain pin, configuration and unused pull-up both give one in the same cycle,
  // so an unused pin's pull never drops while the device enters user mode
  always_comb begin
    pull_up_nxt = 1'b0;
    pull_down_nxt = 1'b0;
    if (cfg_active_i) begin
      pull_up_nxt = !cfg.diff_pin;
    end else if (cfg.mode == gio_pkg::GIO_MODE_UNUSED) begin
      pull_up_nxt = !cfg.pull_down;
      pull_down_nxt = cfg.pull_down && !cfg.diff_pin;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pull_up_r <= gio_pkg::PULL_UP_RST;
      pull_down_r <= gio_pkg::PULL_DOWN_RST;
    end else begin
      pull_up_r <= pull_up_nxt;
      pull_down_r <= pull_down_nxt;
    end
  end

  assign pull_up_o = pull_up_r;
  assign pull_down_o = pull_down_r;

  ////////////////////////////////////////////////////////////////////////////
  // Status
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    status = 32'h0000_0000;
    status[gio_pkg::STAT_PAD_BIT] = pad_sync_r;
    status[gio_pkg::STAT_RISE_BIT] = in_q_rise;
    status[gio_pkg::STAT_FALL_BIT] = in_q_fall;
    status[gio_pkg::STAT_OE_BIT] = oe_q;
    status[gio_pkg::STAT_CFG_BIT] = cfg_active_i;
    status[gio_pkg::STAT_PU_BIT] = pull_up_r;
    status[gio_pkg::STAT_PD_BIT] = pull_down_r;
  end

endmodule // gio_io_logic
`default_nettype wire

// ===== verif/gio_io_logic_props.sv
`timescale 1ns/1ps
`default_nettype none
module gio_io_logic_props (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic cfg_active_i,
  input wire gio_pkg::gio_bus_req_type bus_req_i,
  input wire gio_pkg::gio_drive_type core_drive_i,
  input wire logic rise_sample_out_o,
  input wire logic fall_sample_out_o,
  input wire logic alt_path_o,
  input wire logic pad_i,
  input wire logic pad_o,
  input wire logic pad_oe_o,
  input wire logic pull_up_o,
  input wire logic pull_down_o
);
  gio_pkg::gio_cfg_type sh_r;
  logic up_r;
  logic dn_r;
  // Mode decodes of the shadow word, plus the user-mode flag and the core data bit
  wire logic usr_w = !cfg_active_i;
  wire logic unu_w = sh_r.mode == gio_pkg::GIO_MODE_UNUSED;
  wire logic inm_w = sh_r.mode == gio_pkg::GIO_MODE_INPUT;
  wire logic in_w = inm_w && !sh_r.alt_sel;
  wire logic drv_w = core_drive_i.data_rise;
  wire logic out_w = sh_r.mode == gio_pkg::GIO_MODE_OUTPUT;
  wire logic bid_w = sh_r.mode == gio_pkg::GIO_MODE_BIDIR;
  ////////////////////////////////////////////////////////////////////////////////
  // Shadow of the control word; pulls lag it by one edge, as the pads do
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sh_r <= '0;
      up_r <= gio_pkg::PULL_UP_RST;
      dn_r <= gio_pkg::PULL_DOWN_RST;
    end else begin
      if (bus_req_i.wr && bus_req_i.addr == gio_pkg::CTRL_OFS) begin
        sh_r <= gio_pkg::gio_cfg_type'(bus_req_i.wdata[14:0]);
      end
      up_r <= cfg_active_i ? !sh_r.diff_pin : unu_w && !sh_r.pull_down;
      dn_r <= usr_w && unu_w && sh_r.pull_down && !sh_r.diff_pin;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // Two user cycles under one word, so a flop's last capture is known
  sequence steady_s;
    usr_w ##1 usr_w && $stable(sh_r);
  endsequence
  alt_pass_a: assert property (alt_path_o == (inm_w && sh_r.alt_sel && pad_i))
    else $error("alt path wrong");
  clk_out_a: assert property (usr_w && sh_r.mode == gio_pkg::GIO_MODE_CLKOUT |-> pad_oe_o)
    else $error("clock out not driven");
  in_comb_a: assert property (in_w && !sh_r.in_reg |-> rise_sample_out_o == pad_i)
    else $error("direct input wrong");
  in_reg_a: assert property (steady_s ##0 (in_w && sh_r.in_reg && !sh_r.in_fall)
    |-> rise_sample_out_o == $past(pad_i))
    else $error("input flop wrong");
  fall_sample_a: assert property (@(negedge clk_i) disable iff (!arst_n_i)
    (in_w && sh_r.in_reg && sh_r.dual_edge_in) [*2] |-> fall_sample_out_o == $past(pad_i))
    else $error("fall sample wrong");
  out_reg_a: assert property (steady_s ##0 (out_w && sh_r.out_reg && !sh_r.out_fall
    && !sh_r.dual_edge_out) |-> pad_o == ($past(drv_w) ^ sh_r.out_inv))
    else $error("output flop wrong");
  bidir_oe_a: assert property (usr_w && bid_w && !sh_r.oe_reg
    |-> pad_oe_o == core_drive_i.oe)
    else $error("enable wrong");
  in_float_a: assert property (inm_w |-> !pad_oe_o)
    else $error("input pin driven");
  cfg_float_a: assert property (!usr_w |-> !pad_oe_o)
    else $error("pin driven in configuration");
  pull_up_a: assert property (pull_up_o == up_r)
    else $error("pull up wrong");
  pull_dn_a: assert property (pull_down_o == dn_r)
    else $error("pull down wrong");
endmodule // gio_io_logic_props
`default_nettype wire

// ===== verif/gio_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
// Pad: our driver wins while enabled, else the outside device drives it
// One pin only, so the per-bank cap on differential drivers is kept
module gio_pad_model (
  input wire logic pad_o_i,
  input wire logic pad_oe_i,
  input wire logic ext_val_i,
  output logic pad_lvl_o
);
  assign pad_lvl_o = pad_oe_i ? pad_o_i : ext_val_i;
endmodule // gio_pad_model
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic cfg_active_i = 1'b1;
  logic ext_val = 1'b0;
  gio_pkg::gio_bus_req_type bus_req_i = '0;
  gio_pkg::gio_drive_type core_drive_i = '0;
  gio_pkg::gio_cfg_type cfg = '0;
  logic [31:0] rd_data_o, seed = 32'h0001_4F54, v, d;
  logic rise_o, fall_o, alt_o, pad_i, pad_o, pad_oe_o, pu_o, pd_o;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  // Mode and register choices walked by the main loop
  localparam logic [14:0] CFGS [14] = '{15'h0001, 15'h1001, 15'h0009, 15'h0019, 15'h0409,
    15'h0002, 15'h0022, 15'h0222, 15'h0062, 15'h0A22, 15'h0003, 15'h0023, 15'h03AB, 15'h0004};
  always #2.5 clk_i = !clk_i;
  gio_io_logic u_gio_io_logic (.clk_i(clk_i), .arst_n_i(arst_n_i), .cfg_active_i(cfg_active_i),
    .bus_req_i(bus_req_i), .rd_data_o(rd_data_o), .core_drive_i(core_drive_i),
    .rise_sample_out_o(rise_o), .fall_sample_out_o(fall_o), .alt_path_o(alt_o), .pad_i(pad_i),
    .pad_o(pad_o), .pad_oe_o(pad_oe_o), .pull_up_o(pu_o), .pull_down_o(pd_o));
  gio_pad_model u_gio_pad_model (.pad_o_i(pad_o), .pad_oe_i(pad_oe_o), .ext_val_i(ext_val),
    .pad_lvl_o(pad_i));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Value a pin flop shows in the high or low clock phase after a capture
  function automatic logic q(input logic rg, fl, dd, lo, p, c, cf);
    if (!rg) return c;
    if (dd) return lo ? cf : p;
    return (fl && lo) ? c : p;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Bus cycles start one edge on, so back-to-back calls never collide
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge clk_i);
    bus_req_i <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus_req_i <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    @(posedge clk_i);
    bus_req_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus_req_i <= '0;
    @(negedge clk_i);
    r = rd_data_o;
  endtask
  task automatic phase(input logic lo, input gio_pkg::gio_drive_type p, input logic pp);
    gio_pkg::gio_mode_type m;
    gio_pkg::gio_drive_type c;
    logic e_oe, e_pad, e_in, e_rise, e_fall;
    m = cfg.mode;
    c = core_drive_i;
    e_oe = q(cfg.oe_reg, cfg.oe_fall, 1'b0, lo, p.oe, c.oe, 1'b0);
    e_oe = m == gio_pkg::GIO_MODE_OUTPUT || m == gio_pkg::GIO_MODE_CLKOUT ||
      (m == gio_pkg::GIO_MODE_BIDIR && e_oe);
    e_pad = q(cfg.out_reg, cfg.out_fall, cfg.dual_edge_out, lo, p.data_rise, c.data_rise,
      c.data_fall) ^ (cfg.out_reg & cfg.out_inv);
    if (m == gio_pkg::GIO_MODE_CLKOUT) e_pad = !lo;
    e_in = m == gio_pkg::GIO_MODE_INPUT && !cfg.alt_sel;
    e_rise = e_in && q(cfg.in_reg, cfg.in_fall & !cfg.dual_edge_in, 1'b0, lo, pp, ext_val,
      1'b0);
    e_fall = e_in && cfg.in_reg && cfg.dual_edge_in && (lo ? ext_val : pp);
    check("pad_oe", pad_oe_o, e_oe);
    if (e_oe) check("pad", pad_o, e_pad);
    if (m != gio_pkg::GIO_MODE_BIDIR) check("rise", rise_o, e_rise);
    check("fall", fall_o, e_fall);
    check("alt", alt_o, m == gio_pkg::GIO_MODE_INPUT && cfg.alt_sel && ext_val);
  endtask
  // Random core data and pad levels, checked in both clock phases
  task automatic run(input int n);
    gio_pkg::gio_drive_type p;
    logic pp;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      p = core_drive_i;
      pp = ext_val;
      v = rnd();
      core_drive_i <= gio_pkg::gio_drive_type'(v[2:0]);
      ext_val <= v[7];
      #1 phase(1'b0, p, pp);
      @(negedge clk_i);
      #1 phase(1'b1, p, pp);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    repeat (4) @(posedge clk_i);
    check("rst pulls", {pu_o, pd_o, pad_oe_o}, 3'b100);
    arst_n_i <= 1'b1;
    wr(gio_pkg::CTRL_OFS, 32'h0000_4000);
    // Pulls follow the new control word one edge after it lands
    repeat (2) @(negedge clk_i);
    check("cfg diff pulls", {pu_o, pd_o}, 2'b00);
    wr(gio_pkg::CTRL_OFS, 32'h0);
    // Let the plain-pin pull-up settle before user mode begins
    @(posedge clk_i);
    cfg_active_i <= 1'b0;
    repeat (4) begin
      @(negedge clk_i);
      check("pull up held", pu_o, 1'b1);
    end
    wr(gio_pkg::CTRL_OFS, 32'h0000_2000);
    rd(gio_pkg::STATUS_OFS, d);
    check("status pulls", d & 32'h70, 32'h40);
    $display("test pulls done");
    repeat (4) begin
      v = rnd() & 32'hFFFF_FFF3;
      wr(gio_pkg::CTRL_OFS, v);
      rd(gio_pkg::CTRL_OFS, d);
      check("ctrl", d, v & 32'h0000_7FFF);
    end
    rd(8'h08, d);
    check("unmapped", d, 32'h0);
    $display("test regs done");
    for (int i = 0; i < 14; i++) begin
      cfg = gio_pkg::gio_cfg_type'(CFGS[i]);
      wr(gio_pkg::CTRL_OFS, {17'h0, CFGS[i]});
      run(24);
      $display("test mode %0d done", i);
    end
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    @(negedge clk_i);
    check("rerst pulls", {pu_o, pd_o, pad_oe_o}, 3'b100);
    @(posedge clk_i);
    arst_n_i <= 1'b1;
    cfg = '0;
    run(8);
    $display("test rerst done");
    report_and_stop();
  end
endmodule // tb
bind gio_io_logic gio_io_logic_props u_gio_io_logic_props (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .cfg_active_i(cfg_active_i), .bus_req_i(bus_req_i), .core_drive_i(core_drive_i),
  .rise_sample_out_o(rise_sample_out_o), .fall_sample_out_o(fall_sample_out_o),
  .alt_path_o(alt_path_o), .pad_i(pad_i), .pad_o(pad_o), .pad_oe_o(pad_oe_o),
  .pull_up_o(pull_up_o), .pull_down_o(pull_down_o));
`default_nettype wire
